// File: hw/abo_params.svh
// constants for the accumulator bit operation unit
`ifndef ABO_PARAMS_SVH
`define ABO_PARAMS_SVH

`define ABO_ACC_W        32
`define ABO_CNT_W        6
`define ABO_IDX_W        5
`define ABO_MAX_COUNT    6'h20
`define ABO_ACC_RESET    32'h0000_0000
`define ABO_ERR_RESET    1'b0
`define ABO_DEC_LIMIT    32'h0000_0020
`define ABO_DEC_STEP     5
`define ABO_DEC_PASSES   7
`define ABO_MSB_INDEX    32'h0000_001F

`endif

// File: hw/abo_pkg.sv
// types shared by the accumulator bit operation unit
package abo_pkg;

    typedef enum logic [2:0] {
        ABO_OP_LOAD  = 3'h0,
        ABO_OP_POP   = 3'h1,
        ABO_OP_SHL   = 3'h2,
        ABO_OP_SHR   = 3'h3,
        ABO_OP_ROTATE_LEFT_OP  = 3'h4,
        ABO_OP_ROTATE_RIGHT_OP  = 3'h5,
        ABO_OP_ENC   = 3'h6,
        ABO_OP_DEC   = 3'h7
    } abo_op_e;

    typedef struct packed {
        logic          valid;
        abo_op_e       op;
        logic [5:0]    count;
        logic [31:0]   data;
    } abo_req_s;

endpackage : abo_pkg

// File: hw/abo_unit.sv
// accumulator bit operation datapath: count, shift, rotate, encode, decode
`timescale 1ns/1ps
`include "abo_params.svh"

module abo_unit #(
    parameter int ACC_W = `ABO_ACC_W
) (
    input  wire logic             i_clk,       // 40 MHz clock
    input  wire logic             i_resetn,    // async reset, active low
    input  wire abo_pkg::abo_req_s i_req,      // operation request
    output logic [ACC_W-1:0]      o_acc,       // accumulator
    output logic                  o_range_err, // operand range error flag
    output logic                  o_done       // one-cycle completion pulse
);
    import abo_pkg::*;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function automatic logic [ACC_W-1:0] pop_count(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0] n;
        n = '0;
        for (int i = 0; i < ACC_W; i++) begin
            n = n + {{(ACC_W-1){1'b0}}, v[i]};
        end
        return n;
    endfunction : pop_count

    function automatic logic [ACC_W-1:0] low_index(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0] n;
        logic             hit;
        n   = '0;
        hit = 1'b0;
        for (int i = 0; i < ACC_W; i++) begin
            if (v[i] && !hit) begin
                n   = ACC_W'(i);
                hit = 1'b1;
            end
        end
        return n;
    endfunction : low_index

    function automatic logic [ACC_W-1:0] reduce_idx(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0] r;
        r = v;
        for (int i = 0; i < `ABO_DEC_PASSES; i++) begin
            if (r >= `ABO_DEC_LIMIT) begin
                r = r >> `ABO_DEC_STEP;
            end
        end
        return r;
    endfunction : reduce_idx

    function automatic logic [ACC_W-1:0] rot_left(input logic [ACC_W-1:0] v,
                                                 input logic [4:0]       c);
        logic [2*ACC_W-1:0] w;
        w = {v, v} << c;
        return w[2*ACC_W-1:ACC_W];
    endfunction : rot_left

    function automatic logic [ACC_W-1:0] rot_right(input logic [ACC_W-1:0] v,
                                                  input logic [4:0]       c);
        logic [2*ACC_W-1:0] w;
        w = {v, v} >> c;
        return w[ACC_W-1:0];
    endfunction : rot_right

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic             err_q;
    logic             err_d;
    logic             done_q;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    wire logic [5:0]       cnt        = i_req.count;
    wire logic [4:0]       rot_cnt    = cnt[4:0];
    wire logic [ACC_W-1:0] pop_val    = pop_count(acc_q);
    wire logic [ACC_W-1:0] shl_val    = (cnt >= `ABO_MAX_COUNT) ? '0
                                        : (acc_q << cnt);
    wire logic [ACC_W-1:0] shr_val    = (cnt >= `ABO_MAX_COUNT) ? '0
                                        : (acc_q >> cnt);
    wire logic [ACC_W-1:0] rotate_left_op_val   = rot_left(acc_q, rot_cnt);
    wire logic [ACC_W-1:0] rotate_right_op_val   = rot_right(acc_q, rot_cnt);
    wire logic [ACC_W-1:0] enc_val    = low_index(acc_q);
    wire logic             enc_multi  = (pop_val > ACC_W'(1));
    wire logic [ACC_W-1:0] dec_idx    = reduce_idx(acc_q);
    wire logic [ACC_W-1:0] dec_val    = ACC_W'(1) << dec_idx[4:0];

    always_comb begin
        acc_d = acc_q;
        err_d = err_q;
        if (i_req.valid) begin
            case (i_req.op)
                ABO_OP_LOAD: acc_d = i_req.data;
                ABO_OP_POP:  acc_d = pop_val;
                ABO_OP_SHL:  acc_d = shl_val;
                ABO_OP_SHR:  acc_d = shr_val;
                ABO_OP_ROTATE_LEFT_OP: acc_d = rotate_left_op_val;
                ABO_OP_ROTATE_RIGHT_OP: acc_d = rotate_right_op_val;
                ABO_OP_ENC: begin
                    acc_d = enc_val;
                    err_d = enc_multi;
                end
                ABO_OP_DEC:  acc_d = dec_val;
                default:     acc_d = acc_q;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_q  <= `ABO_ACC_RESET;
            err_q  <= `ABO_ERR_RESET;
            done_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            err_q  <= err_d;
            done_q <= i_req.valid;
        end
    end

    assign o_acc       = acc_q;
    assign o_range_err = err_q;
    assign o_done      = done_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    wire logic is_pop  = i_req.valid && (i_req.op == ABO_OP_POP);
    wire logic is_shl  = i_req.valid && (i_req.op == ABO_OP_SHL);
    wire logic is_shr  = i_req.valid && (i_req.op == ABO_OP_SHR);
    wire logic is_rotate_left_op = i_req.valid && (i_req.op == ABO_OP_ROTATE_LEFT_OP);
    wire logic is_rotate_right_op = i_req.valid && (i_req.op == ABO_OP_ROTATE_RIGHT_OP);
    wire logic is_enc  = i_req.valid && (i_req.op == ABO_OP_ENC);
    wire logic is_dec  = i_req.valid && (i_req.op == ABO_OP_DEC);

    a_pop_count: assert property (
        is_pop |=> acc_q == ACC_W'($countones($past(acc_q)))
    ) else $error("popcount result wrong");

    a_shl_result: assert property (
        is_shl && (i_req.count == 6'h02) |=>
            acc_q == {$past(acc_q[ACC_W-3:0]), 2'b00}
    ) else $error("shift left by two wrong");

    a_shr_full: assert property (
        is_shr && (i_req.count == `ABO_MAX_COUNT) |=> acc_q == '0
    ) else $error("shift right by 32 not zero");

    a_shr_result: assert property (
        is_shr && (i_req.count == 6'h01) |=>
            acc_q == {1'b0, $past(acc_q[ACC_W-1:1])}
    ) else $error("shift right by one wrong");

    a_rotate_left_op_keep: assert property (
        is_rotate_left_op |=> $countones(acc_q) == $countones($past(acc_q))
    ) else $error("rotate left lost bits");

    a_rotate_left_op_one: assert property (
        is_rotate_left_op && (i_req.count == 6'h01) |=>
            acc_q == {$past(acc_q[ACC_W-2:0]), $past(acc_q[ACC_W-1])}
    ) else $error("rotate left by one wrong");

    a_rotate_right_op_one: assert property (
        is_rotate_right_op && (i_req.count == 6'h01) |=>
            acc_q == {$past(acc_q[0]), $past(acc_q[ACC_W-1:1])}
    ) else $error("rotate right by one wrong");

    a_rot_full: assert property (
        (is_rotate_left_op || is_rotate_right_op) && (i_req.count == `ABO_MAX_COUNT) |=> $stable(acc_q)
    ) else $error("rotate by 32 changed value");

    a_enc_msb: assert property (
        is_enc && (acc_q == 32'h8000_0000) |=> (acc_q == `ABO_MSB_INDEX) && !err_q
    ) else $error("encode of bit 31 wrong");

    a_enc_low: assert property (
        is_enc && (acc_q <= 32'h0000_0001) |=> (acc_q == '0) && !err_q
    ) else $error("encode of zero or one wrong");

    a_enc_multi: assert property (
        is_enc && ($countones(acc_q) > 1) |=>
            err_q && (acc_q < 32'h20)
            && ((($past(acc_q) >> acc_q[4:0]) & 32'h1) == 32'h1)
            && (($past(acc_q) & ((32'h1 << acc_q[4:0]) - 32'h1)) == '0)
    ) else $error("encode of several bits wrong");

    a_err_hold: assert property (
        !is_enc |=> $stable(err_q)
    ) else $error("error flag changed without encode");

    a_dec_onehot: assert property (
        is_dec |=> $onehot(acc_q)
    ) else $error("decode result not one-hot");

    a_dec_index: assert property (
        is_dec && (acc_q < 32'h20) |=> acc_q == (32'h1 << $past(acc_q[4:0]))
    ) else $error("decode index wrong");

    a_dec_f: assert property (
        is_dec && (acc_q == 32'h0000_000F) |=> acc_q == 32'h0000_8000
    ) else $error("decode of F wrong");

    a_dec_big: assert property (
        is_dec && (acc_q == 32'h0000_0060) |=> acc_q == 32'h0000_0008
    ) else $error("decode of large value wrong");

    a_idle_hold: assert property (
        !i_req.valid |=> $stable(acc_q) && $stable(err_q) && !o_done
    ) else $error("state changed with no request");

    a_done_pulse: assert property (
        i_req.valid |=> o_done
    ) else $error("done missing after request");

    // ends of the count range, result widths, and more rotate, encode, error flag and decode checks
    a_shl_full: assert property (
        is_shl && (i_req.count == `ABO_MAX_COUNT) |=> acc_q == '0
    ) else $error("shift left by 32 not zero");

    a_shl_top: assert property (
        is_shl && (i_req.count == 6'h1F) |=> acc_q == {$past(acc_q[0]), 31'h0}
    ) else $error("shift left by 31 wrong");

    a_shr_low: assert property (
        is_shr && (i_req.count == 6'h1F) |=> acc_q == {31'h0, $past(acc_q[ACC_W-1])}
    ) else $error("shift right by 31 wrong");

    a_rotate_right_op_keep: assert property (
        is_rotate_right_op |=> $countones(acc_q) == $countones($past(acc_q))
    ) else $error("rotate right lost bits");

    a_rotate_left_op_two: assert property (
        is_rotate_left_op && (i_req.count == 6'h02) |=>
            acc_q == {$past(acc_q[ACC_W-3:0]), $past(acc_q[ACC_W-1:ACC_W-2])}
    ) else $error("rotate left by two wrong");

    a_rotate_right_op_two: assert property (
        is_rotate_right_op && (i_req.count == 6'h02) |=>
            acc_q == {$past(acc_q[1:0]), $past(acc_q[ACC_W-1:2])}
    ) else $error("rotate right by two wrong");

    a_enc_single: assert property (
        is_enc && $onehot(acc_q) |=> !err_q && ($past(acc_q) == (32'h1 << acc_q[4:0]))
    ) else $error("encode of one bit wrong");

    a_enc_width: assert property (
        is_enc |=> acc_q < 32'h20
    ) else $error("encode result too wide");

    a_pop_width: assert property (
        is_pop |=> acc_q <= 32'h20
    ) else $error("popcount result too wide");

    a_err_clear: assert property (
        is_enc && ($countones(acc_q) <= 1) |=> !err_q
    ) else $error("error flag not cleared by encode");

    a_err_source: assert property (
        $rose(err_q) |-> $past(is_enc)
    ) else $error("error flag raised without encode");

    a_dec_reduce: assert property (
        is_dec && (acc_q >= 32'h20) && (acc_q < 32'h400) |=>
            acc_q == (32'h1 << $past(acc_q[9:5]))
    ) else $error("decode of reduced value wrong");

    a_dec_top: assert property (
        is_dec && (acc_q == 32'h0000_001F) |=> acc_q == 32'h8000_0000
    ) else $error("decode of 1F wrong");

    c_enc_multi: cover property (is_enc && $countones(acc_q) > 1 ##1 err_q);
    c_dec_big:   cover property (is_dec && acc_q >= 32'h20);
    c_rot_chain: cover property (is_rotate_left_op ##1 is_rotate_right_op);
    c_err_clear: cover property (err_q ##1 is_enc ##1 !err_q);
    c_shift_full: cover property (is_shl && (i_req.count == `ABO_MAX_COUNT));

endmodule : abo_unit

// File: verif/abo_seq_model.sv
// sequencer model that issues one-cycle requests to the bit operation unit
`timescale 1ns/1ps
module abo_seq_model (
    input  wire logic         i_clk, // unit clock
    output abo_pkg::abo_req_s o_req  // request to the unit
);
    import abo_pkg::*;
    logic [31:0] last_q;
    initial begin
        o_req  = '0;
        last_q = 32'h0000_0000;
    end
    // ----------------------------------------
    // issue: one request, held for one cycle
    // ----------------------------------------
    task automatic issue(input abo_op_e op, input logic [5:0] cnt, input logic [31:0] d);
        logic [31:0] w;
        w = (op == ABO_OP_LOAD) ? d : ~last_q;
        @(posedge i_clk);
        o_req.valid <= 1'b1;
        o_req.op    <= op;
        o_req.count <= cnt;
        o_req.data  <= w;
        last_q      <= w;
        @(posedge i_clk);
        o_req.valid <= 1'b0;
        o_req.count <= ~cnt;
        o_req.data  <= ~w;
    endtask : issue
endmodule : abo_seq_model

// File: verif/tb_top.sv
// self-checking bench for the accumulator bit operation unit
`timescale 1ns/1ps
module tb_top;
    import abo_pkg::*;
    localparam logic [31:0] PAT = 32'hC000_0003;
    logic        i_clk;
    logic        i_resetn;
    abo_req_s    req;
    logic [31:0] acc;
    logic        rerr;
    logic        done;
    int          error_cnt;
    int          cmp_count;

    abo_seq_model i_abo_seq_model (.i_clk(i_clk), .o_req(req));
    abo_unit #(.ACC_W(32)) i_abo_unit (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req),
        .o_acc(acc), .o_range_err(rerr), .o_done(done));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic run(input abo_op_e op, input logic [5:0] c, input logic [31:0] d);
        i_abo_seq_model.issue(op, c, d);
        #1;
        chk("done", 32'h0000_0001, {31'h0, done});
    endtask : run
    task automatic opchk(input abo_op_e op, input logic [5:0] c, input logic [31:0] din,
                         input logic [31:0] exp);
        run(ABO_OP_LOAD, 6'h00, din);
        run(op, c, 32'h0000_0000);
        chk(op.name(), exp, acc);
    endtask : opchk
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_pop();
        opchk(ABO_OP_POP, 6'h00, 32'hF0F0_0001, 32'h0000_0009);
        opchk(ABO_OP_POP, 6'h00, 32'hFFFF_FFFF, 32'h0000_0020);
        $display("test pop done");
    endtask : t_pop
    task automatic t_shift();
        logic [5:0] cnt [4] = '{6'h01, 6'h02, 6'h1F, 6'h20};
        foreach (cnt[k]) begin
            opchk(ABO_OP_SHL, cnt[k], PAT, PAT << cnt[k]);
            opchk(ABO_OP_SHR, cnt[k], PAT, PAT >> cnt[k]);
            opchk(ABO_OP_ROTATE_LEFT_OP, cnt[k], PAT, (PAT << cnt[k]) | (PAT >> (6'h20 - cnt[k])));
            opchk(ABO_OP_ROTATE_RIGHT_OP, cnt[k], PAT, (PAT >> cnt[k]) | (PAT << (6'h20 - cnt[k])));
        end
        $display("test shift and rotate done");
    endtask : t_shift
    task automatic t_enc();
        logic [31:0] din [5] = '{32'h8000_0000, 32'h0, 32'h1, 32'h0000_0400, 32'h0000_0600};
        logic [31:0] exp [5] = '{32'h0000_001F, 32'h0, 32'h0, 32'h0000_000A, 32'h0000_0009};
        logic        err [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        foreach (din[k]) begin
            opchk(ABO_OP_ENC, 6'h00, din[k], exp[k]);
            chk("range_err", {31'h0, err[k]}, {31'h0, rerr});
        end
        run(ABO_OP_SHL, 6'h01, 32'h0000_0000);
        chk("range_err_kept", 32'h0000_0001, {31'h0, rerr});
        opchk(ABO_OP_ENC, 6'h00, 32'h0000_0010, 32'h0000_0004);
        chk("range_err_clr", 32'h0000_0000, {31'h0, rerr});
        $display("test encode done");
    endtask : t_enc
    task automatic t_dec();
        logic [31:0] din [5] = '{32'hF, 32'h0, 32'h1F, 32'h60, 32'h400};
        logic [31:0] exp [5] = '{32'h8000, 32'h1, 32'h8000_0000, 32'h8, 32'h2};
        foreach (din[k]) begin
            opchk(ABO_OP_DEC, 6'h00, din[k], exp[k]);
        end
        $display("test decode done");
    endtask : t_dec
    task automatic t_idle();
        run(ABO_OP_LOAD, 6'h00, 32'h1234_5678);
        @(posedge i_clk);
        #1;
        chk("done_idle", 32'h0000_0000, {31'h0, done});
        chk("acc_idle", 32'h1234_5678, acc);
        $display("test idle done");
    endtask : t_idle
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    initial begin
        #(3000 * 25);
        error_cnt++;
        final_report();
    end
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        i_resetn  = 1'b0;
        repeat (20) @(posedge i_clk);
        chk("acc_rst", 32'h0000_0000, acc);
        chk("err_rst", 32'h0000_0000, {31'h0, rerr});
        i_resetn <= 1'b1;
        t_pop();
        t_shift();
        t_enc();
        t_dec();
        t_idle();
        final_report();
    end
endmodule : tb_top
